// File: rtl/ssf_pkg.sv
// Purpose: shared constants for the scan status flag block
// Assumes: 40 MHz system clock, AXI4-Lite register access
// Notes:   bit positions, register offsets, timing and error codes
package ssf_pkg;

    // clock rate and time base figures
    localparam int CLK_KHZ          = 40000;
    localparam int FAST_HALF_MS     = 500;
    localparam int SLOW_HALF_MS     = 30000;
    localparam int FAST_HALF_CYCLES = FAST_HALF_MS * CLK_KHZ;
    localparam int SLOW_PER_FAST    = SLOW_HALF_MS / FAST_HALF_MS;

    // system status byte bit positions
    localparam int ST_ALWAYS_ON = 0;
    localparam int ST_FIRST     = 1;
    localparam int ST_RET_LOSS  = 2;
    localparam int ST_PWR_RUN   = 3;
    localparam int ST_SLOW      = 4;
    localparam int ST_FAST      = 5;
    localparam int ST_TOGGLE    = 6;
    localparam int ST_MODE      = 7;

    // instruction error byte bit positions
    localparam int ER_ZERO     = 0;
    localparam int ER_OVERFLOW = 1;
    localparam int ER_NEGATIVE = 2;
    localparam int ER_DIV_ZERO = 3;
    localparam int ER_TBL_FULL = 4;
    localparam int ER_TBL_EMPT = 5;
    localparam int ER_BAD_BCD  = 6;
    localparam int ER_BAD_CHAR = 7;

    // reset values
    localparam logic [7:0]  STATUS_RST  = 8'h01;
    localparam logic [7:0]  ERROR_RST   = 8'h00;
    localparam logic [15:0] COMPILE_RST = 16'h0000;
    localparam logic [1:0]  CTRL_RST    = 2'h0;

    // compile error code range
    localparam logic [15:0] COMPILE_BASE = 16'h0080;
    localparam logic [4:0]  COMPILE_LAST = 5'h16;

    // register map, byte addresses
    localparam int          AXI_ADDR_W   = 4;
    localparam logic [3:0]  OFS_STATUS   = 4'h0;
    localparam logic [3:0]  OFS_ERROR    = 4'h4;
    localparam logic [3:0]  OFS_COMPILE  = 4'h8;
    localparam logic [3:0]  OFS_CTRL     = 4'hc;

    // control register fields
    localparam int CTRL_FREEZE  = 0;
    localparam int CTRL_CLR_CMP = 1;

    // bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage

// File: rtl/ssf_flags.sv
// Purpose: system status byte, instruction error byte, compile error code
// Assumes: scan_end and event inputs are single-cycle pulses synchronous
//          to clk; registers reached over AXI4-Lite
// Notes:   status byte is loaded only on scan_end; time bases run unless the control freeze bit is set
//
// The implementer's own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
module ssf_flags #(
    parameter int FAST_CYCLES = ssf_pkg::FAST_HALF_CYCLES,
    parameter int SLOW_HALVES = ssf_pkg::SLOW_PER_FAST
) (
    // clock and reset
    input  wire logic                          clk,
    input  wire logic                          reset,
    // scan sequencing
    input  wire logic                          scan_end,
    input  wire logic                          run_entry,
    input  wire logic                          run_from_power_up,
    input  wire logic                          retentive_lost,
    input  wire logic                          mode_run,
    // instruction execution
    input  wire logic                          exec_valid,
    input  wire logic [7:0]                    exec_mask,
    input  wire logic [7:0]                    exec_flags,
    input  wire logic [15:0]                   exec_result,
    input  wire logic                          exec_signed,
    // program download compiler
    input  wire logic                          compile_fault,
    input  wire logic [4:0]                    compile_rule,
    input  wire logic                          download_start,
    output logic                               download_abort,
    // flag values to the program engine
    output logic [7:0]                         system_status_byte,
    output logic [7:0]                         instruction_error_byte,
    output logic [15:0]                        compile_code,
    // axi4-lite slave
    input  wire logic [ssf_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    input  wire logic [31:0]                   s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    output logic [1:0]                         s_axi_bresp,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    input  wire logic [ssf_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    output logic [31:0]                        s_axi_rdata,
    output logic [1:0]                         s_axi_rresp,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready
);
    import ssf_pkg::*;

    localparam int FW = $clog2(FAST_CYCLES + 1);
    localparam int SW = $clog2(SLOW_HALVES + 1);
    localparam logic [FW-1:0] FAST_LAST = FW'(FAST_CYCLES - 1);
    localparam logic [SW-1:0] SLOW_LAST = SW'(SLOW_HALVES - 1);

    // refuse time bases the counters cannot serve
    if (FAST_CYCLES < 1 || SLOW_HALVES < 1) begin : g_bad_param
        $error("time base counts must be at least one");
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    ////////////////////////////////////////////////////////////////////////
    // state
    logic [7:0]    status_q;
    logic [7:0]    status_d;
    logic [7:0]    error_q;
    logic [7:0]    error_d;
    logic [15:0]   compile_q;
    logic [15:0]   compile_d;
    logic [1:0]    ctrl_q;
    logic          abort_q;
    logic          first_pend_q;
    logic          ret_pend_q;
    logic          pwr_pend_q;
    logic [FW-1:0] fast_cnt_q;
    logic [SW-1:0] slow_cnt_q;
    logic          fast_q;
    logic          slow_q;

    ////////////////////////////////////////////////////////////////////////
    // time bases: half-second wave and thirty-second wave
    wire tb_run    = !ctrl_q[CTRL_FREEZE];
    wire fast_wrap = tb_run && (fast_cnt_q == FAST_LAST);
    wire slow_wrap = fast_wrap && (slow_cnt_q == SLOW_LAST);

    always_ff @(posedge clk) begin
        if (reset) begin
            fast_cnt_q <= '0;
            slow_cnt_q <= '0;
            fast_q     <= 1'b0;
            slow_q     <= 1'b0;
        end else if (tb_run) begin
            fast_cnt_q <= fast_wrap ? '0 : fast_cnt_q + 1'b1;
            if (fast_wrap) begin
                fast_q     <= !fast_q;
                slow_cnt_q <= slow_wrap ? '0 : slow_cnt_q + 1'b1;
            end
            if (slow_wrap) begin
                slow_q <= !slow_q;
            end
        end
    end

    a_fast_period: assert property (
        fast_wrap |=> (fast_q != $past(fast_q)) && (fast_cnt_q == '0))
        else $error("fast wave did not flip at its half period");
    a_slow_period: assert property (
        (tb_run && !slow_wrap) |=> $stable(slow_q))
        else $error("slow wave changed away from its half period");

    ////////////////////////////////////////////////////////////////////////
    // one-scan event capture; a new event on scan_end waits for next scan
    // first scan armed by run entry
    // retentive loss held to next scan
    // power-up run held to next scan
    always_ff @(posedge clk) begin
        if (reset) begin
            first_pend_q <= 1'b0;
            ret_pend_q   <= 1'b0;
            pwr_pend_q   <= 1'b0;
        end else begin
            first_pend_q <= run_entry || (first_pend_q && !scan_end);
            ret_pend_q   <= retentive_lost || (ret_pend_q && !scan_end);
            pwr_pend_q   <= (run_entry && run_from_power_up)
                            || (pwr_pend_q && !scan_end);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // next system status byte
    // constant one
    always_comb begin
        status_d               = status_q;
        status_d[ST_ALWAYS_ON] = 1'b1;
        status_d[ST_FIRST]     = first_pend_q;
        status_d[ST_RET_LOSS]  = ret_pend_q;
        status_d[ST_PWR_RUN]   = pwr_pend_q;
        status_d[ST_SLOW]      = slow_q;
        status_d[ST_FAST]      = fast_q;
        status_d[ST_TOGGLE]    = !status_q[ST_TOGGLE];
        status_d[ST_MODE]      = mode_run;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            status_q <= STATUS_RST;
        end else if (scan_end) begin
            status_q <= status_d;
        end
    end

    a_refresh_hold: assert property (
        !scan_end |=> $stable(status_q))
        else $error("status byte changed outside scan end");
    a_always_on: assert property (
        status_q[ST_ALWAYS_ON])
        else $error("always-on bit read low");
    a_first_once: assert property (
        (scan_end && !run_entry && !first_pend_q) |=> !status_q[ST_FIRST])
        else $error("first-scan bit high on a later scan");
    a_retentive_one: assert property (
        (scan_end && retentive_lost) ##1 (!retentive_lost [*1])
        ##0 scan_end |=> status_q[ST_RET_LOSS])
        else $error("retentive-loss bit missed its scan");
    a_power_run_one: assert property (
        (scan_end && status_q[ST_PWR_RUN] && !pwr_pend_q)
        |=> !status_q[ST_PWR_RUN])
        else $error("power-up-run bit held beyond one scan");
    a_scan_toggle: assert property (
        scan_end |=> status_q[ST_TOGGLE] != $past(status_q[ST_TOGGLE]))
        else $error("scan toggle did not invert");
    a_mode_follow: assert property (
        scan_end |=> status_q[ST_MODE] == $past(mode_run))
        else $error("mode bit does not follow switch");

    ////////////////////////////////////////////////////////////////////////
    // instruction error byte: masked bits take the instruction's outcome
    wire       res_zero = (exec_result == 16'h0000);
    wire       res_neg  = exec_signed && exec_result[15];
    wire [7:0] exec_val;

    assign exec_val = {exec_flags[ER_BAD_CHAR], exec_flags[ER_BAD_BCD],
                       exec_flags[ER_TBL_EMPT], exec_flags[ER_TBL_FULL],
                       exec_flags[ER_DIV_ZERO], res_neg,
                       exec_flags[ER_OVERFLOW], res_zero};

    assign error_d = (error_q & ~exec_mask) | (exec_val & exec_mask);

    always_ff @(posedge clk) begin
        if (reset) begin
            error_q <= ERROR_RST;
        end else if (exec_valid) begin
            error_q <= error_d;
        end
    end

    a_error_hold: assert property (
        !exec_valid |=> $stable(error_q))
        else $error("error byte changed with no instruction");
    a_zero_flag: assert property (
        (exec_valid && exec_mask[ER_ZERO])
        |=> error_q[ER_ZERO] == ($past(exec_result) == 16'h0000))
        else $error("zero flag does not match result");
    a_neg_flag: assert property (
        (exec_valid && exec_mask[ER_NEGATIVE] && exec_signed
         && exec_result[15]) |=> error_q[ER_NEGATIVE])
        else $error("negative result left flag low");
    a_divzero_flag: assert property (
        (exec_valid && exec_mask[ER_DIV_ZERO] && exec_flags[ER_DIV_ZERO])
        |=> error_q[ER_DIV_ZERO]
        ##1 ($past(exec_valid) || error_q[ER_DIV_ZERO]))
        else $error("divide-by-zero flag not raised");

    ////////////////////////////////////////////////////////////////////////
    // compile error reporting
    wire rule_ok  = (compile_rule <= COMPILE_LAST);
    wire cmp_set  = compile_fault && rule_ok;
    logic cmp_clr;

    // code is base plus rule index
    // a set outranks a clear in the same cycle
    always_comb begin
        compile_d = compile_q;
        if (cmp_clr) begin
            compile_d = COMPILE_RST;
        end
        if (cmp_set) begin
            compile_d = COMPILE_BASE + {11'h000, compile_rule};
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            compile_q <= COMPILE_RST;
            abort_q   <= 1'b0;
        end else begin
            compile_q <= compile_d;
            abort_q   <= cmp_set;
        end
    end

    a_compile_code: assert property (
        cmp_set |=> (compile_q == COMPILE_BASE + {11'h000,
                     $past(compile_rule)}) && abort_q)
        else $error("compile code or abort wrong");
    a_abort_pulse: assert property (
        abort_q |-> $past(compile_fault) ##1 (abort_q == $past(cmp_set)))
        else $error("abort pulse without a compile fault");
    a_reset_state: assert property (
        @(posedge clk) disable iff (1'b0) reset |=> (status_q == STATUS_RST)
        && (error_q == ERROR_RST) && !fast_q && !slow_q)
        else $error("reset did not clear the flags");

    ////////////////////////////////////////////////////////////////////////
    // axi4-lite write channel: address and data taken in either order
    logic                  aw_have_q;
    logic                  w_have_q;
    logic [AXI_ADDR_W-1:0] aw_addr_q;
    logic [31:0]           w_data_q;
    logic [3:0]            w_strb_q;
    logic                  bvalid_q;
    logic [1:0]            bresp_q;

    wire aw_take  = s_axi_awvalid && s_axi_awready;
    wire w_take   = s_axi_wvalid && s_axi_wready;
    wire wr_fire  = aw_have_q && w_have_q && !bvalid_q;
    wire wr_ctrl  = wr_fire && (aw_addr_q == OFS_CTRL) && w_strb_q[0];
    wire wr_known = (aw_addr_q == OFS_STATUS) || (aw_addr_q == OFS_ERROR)
                    || (aw_addr_q == OFS_COMPILE) || (aw_addr_q == OFS_CTRL);

    assign s_axi_awready = !aw_have_q && !bvalid_q;
    assign s_axi_wready  = !w_have_q && !bvalid_q;
    assign cmp_clr       = (wr_ctrl && w_data_q[CTRL_CLR_CMP])
                           || download_start;

    always_ff @(posedge clk) begin
        if (reset) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            aw_addr_q <= '0;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (w_take) begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_have_q <= 1'b0;
                w_have_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= wr_known ? RESP_OKAY : RESP_DECERR;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // control register: freeze bit is stored, clear bit self-clears
    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl_q <= CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_q[CTRL_FREEZE] <= w_data_q[CTRL_FREEZE];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // axi4-lite read channel: one cycle from address to data
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;
    logic [31:0] rd_word;
    logic        rd_known;

    wire ar_take = s_axi_arvalid && s_axi_arready;
    assign s_axi_arready = !rvalid_q;

    // read decode
    always_comb begin
        rd_known = 1'b1;
        unique case (s_axi_araddr)
            OFS_STATUS:  rd_word = {24'h000000, status_q};
            OFS_ERROR:   rd_word = {24'h000000, error_q};
            OFS_COMPILE: rd_word = {16'h0000, compile_q};
            OFS_CTRL:    rd_word = {31'h00000000, ctrl_q[CTRL_FREEZE]};
            default: begin
                rd_word  = 32'h0000_0000;
                rd_known = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= RESP_OKAY;
        end else if (ar_take) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_word;
            rresp_q  <= rd_known ? RESP_OKAY : RESP_DECERR;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    a_read_answer: assert property (
        ar_take |=> s_axi_rvalid)
        else $error("read answer did not follow address");

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign s_axi_bvalid           = bvalid_q;
    assign s_axi_bresp            = bresp_q;
    assign s_axi_rvalid           = rvalid_q;
    assign s_axi_rdata            = rdata_q;
    assign s_axi_rresp            = rresp_q;
    assign download_abort         = abort_q;
    assign system_status_byte     = status_q;
    assign instruction_error_byte = error_q;
    assign compile_code           = compile_q;

endmodule

// File: bench/scan_status_flags_tb.sv
// Purpose: self-checking bench for the scan status flag block
// Assumes: short time bases (4-cycle fast half, 3 fast halves per slow)
// Notes:   inputs change by non-blocking assignment at the rising edge
`timescale 1ns/1ps

module scan_status_flags_tb;
    import ssf_pkg::*;

    localparam int FC = 4;
    localparam int SH = 3;
    // stimulus, all driven from time zero
    logic        clk = 1'b0, reset = 1'b1, scan_end = 1'b0, run_entry = 1'b0;
    logic        run_from_power_up = 1'b0, retentive_lost = 1'b0;
    logic        mode_run = 1'b0, exec_valid = 1'b0, exec_signed = 1'b0;
    logic        compile_fault = 1'b0, download_start = 1'b0;
    logic [7:0]  exec_mask = 8'h00, exec_flags = 8'h00;
    logic [15:0] exec_result = 16'h0001;
    logic [4:0]  compile_rule = 5'h00;
    logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    // observed outputs
    logic        download_abort, awready, wready, bvalid, arready, rvalid;
    logic [7:0]  ssb, ieb;
    logic [15:0] ccode;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    int          error_cnt = 0;
    int          checked = 0;

    ssf_flags #(.FAST_CYCLES(FC), .SLOW_HALVES(SH)) i_dut (
        .clk(clk), .reset(reset), .scan_end(scan_end), .run_entry(run_entry),
        .run_from_power_up(run_from_power_up),
        .retentive_lost(retentive_lost), .mode_run(mode_run),
        .exec_valid(exec_valid), .exec_mask(exec_mask),
        .exec_flags(exec_flags), .exec_result(exec_result),
        .exec_signed(exec_signed), .compile_fault(compile_fault),
        .compile_rule(compile_rule), .download_start(download_start),
        .download_abort(download_abort), .system_status_byte(ssb),
        .instruction_error_byte(ieb), .compile_code(ccode),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    ////////////////////////////////////////////////////////////////////////
    // clock, 25 ns period
    always #12.5 clk = ~clk;

    // compare one result and count it
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // bus read, then compare data and response
    task rd(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge clk);
        arvalid <= 1'b1;
        araddr  <= a;
        rready  <= 1'b1;
        @(posedge clk);
        while (!arready) @(posedge clk);
        arvalid <= 1'b0;
        while (!rvalid) @(posedge clk);
        rready <= 1'b0;
        chk(rdata, e);
        chk(rresp, er);
    endtask

    // bus write, address and data offered together
    task wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ad, wd;
        ad = 1'b0;
        wd = 1'b0;
        @(posedge clk);
        {awvalid, wvalid, bready} <= 3'h7;
        awaddr <= a;
        wdata  <= d;
        wstrb  <= 4'hf;
        while (!(ad && wd)) begin
            @(posedge clk);
            if (awvalid && awready) ad = 1'b1;
            if (wvalid && wready) wd = 1'b1;
            if (ad) awvalid <= 1'b0;
            if (wd) wvalid <= 1'b0;
        end
        while (!bvalid) @(posedge clk);
        bready <= 1'b0;
        chk(bresp, er);
    endtask

    // one scan end, optional loss event in the same cycle
    task scan_chk(input logic ev, input logic [7:0] e);
        @(posedge clk);
        scan_end       <= 1'b1;
        retentive_lost <= ev;
        @(posedge clk);
        scan_end       <= 1'b0;
        retentive_lost <= 1'b0;
        #1 chk(ssb & 8'h8f, e);
    endtask

    // one executed instruction and the error byte after it
    task exe(input logic [7:0] m, f, input logic [15:0] r, input logic s,
             input logic [7:0] e);
        @(posedge clk);
        {exec_valid, exec_signed} <= {1'b1, s};
        {exec_mask, exec_flags, exec_result} <= {m, f, r};
        @(posedge clk);
        exec_valid <= 1'b0;
        #1 chk(ieb, e);
    endtask

    // one compile fault and the code and abort after it
    task flt(input logic [4:0] n, input logic [15:0] e, input logic ab);
        @(posedge clk);
        compile_fault <= 1'b1;
        compile_rule  <= n;
        @(posedge clk);
        compile_fault <= 1'b0;
        #1 chk(ccode, e);
        chk(download_abort, ab);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // scenarios
    task t_reset;
        rd(OFS_STATUS, 32'h1, RESP_OKAY);
        rd(OFS_ERROR, 32'h0, RESP_OKAY);
        rd(OFS_COMPILE, 32'h0, RESP_OKAY);
        rd(4'h2, 32'h0, RESP_DECERR);
        $display("reset values done");
    endtask

    // scan every cycle: run lengths of both waves, toggle every scan
    task t_wave;
        logic [7:0] p;
        int nf, ns;
        nf = -999;
        ns = -999;
        // mid-run reset so the waves are known to restart low
        @(posedge clk);
        reset <= 1'b1;
        @(posedge clk);
        {reset, mode_run, scan_end} <= 3'h3;
        @(posedge clk);
        @(posedge clk);
        #1 p = ssb;
        chk(p & 8'hb1, 8'h81);
        repeat (64) begin
            @(posedge clk);
            #1 chk(ssb[ST_TOGGLE] ^ p[ST_TOGGLE], 32'h1);
            if (ssb[ST_FAST] !== p[ST_FAST]) begin
                if (nf > 0) chk(nf, FC);
                nf = 1;
            end else nf++;
            if (ssb[ST_SLOW] !== p[ST_SLOW]) begin
                if (ns > 0) chk(ns, FC * SH);
                ns = 1;
            end else ns++;
            p = ssb;
        end
        // loss pulse while scans end every cycle: one scan late, one scan long
        @(posedge clk);
        retentive_lost <= 1'b1;
        @(posedge clk);
        retentive_lost <= 1'b0;
        @(posedge clk);
        #1 chk(ssb[ST_RET_LOSS], 32'h1);
        @(posedge clk);
        #1 chk(ssb[ST_RET_LOSS], 32'h0);
        @(posedge clk);
        {mode_run, scan_end} <= 2'h0;
        $display("waves done");
    endtask

    task t_scan;
        @(posedge clk);
        {run_entry, run_from_power_up} <= 2'h3;
        @(posedge clk);
        run_entry <= 1'b0;
        scan_chk(1'b0, 8'h0b);
        scan_chk(1'b1, 8'h01);
        scan_chk(1'b0, 8'h05);
        scan_chk(1'b0, 8'h01);
        $display("scan bits done");
    endtask

    task t_exec;
        exe(8'hff, 8'h00, 16'h0000, 1'b0, 8'h01);
        exe(8'hff, 8'h00, 16'h8000, 1'b1, 8'h04);
        exe(8'hff, 8'h02, 16'h1, 1'b0, 8'h02);
        exe(8'hff, 8'h08, 16'h1, 1'b0, 8'h08);
        exe(8'hff, 8'h10, 16'h1, 1'b0, 8'h10);
        exe(8'hff, 8'h20, 16'h1, 1'b0, 8'h20);
        exe(8'hff, 8'h40, 16'h1, 1'b0, 8'h40);
        exe(8'hff, 8'h80, 16'h1, 1'b0, 8'h80);
        exe(8'hff, 8'hfa, 16'h8000, 1'b1, 8'hfe);
        exe(8'h01, 8'h00, 16'h0000, 1'b0, 8'hff);
        exe(8'hfe, 8'h00, 16'h0001, 1'b0, 8'h01);
        $display("error byte done");
    endtask

    task t_comp;
        flt(5'h13, 16'h0093, 1'b1);
        #25 chk(download_abort, 32'h0);
        rd(OFS_COMPILE, 32'h93, RESP_OKAY);
        flt(5'h17, 16'h0093, 1'b0);
        flt(5'h16, 16'h0096, 1'b1);
        @(posedge clk);
        download_start <= 1'b1;
        @(posedge clk);
        download_start <= 1'b0;
        #1 chk(ccode, 32'h0);
        flt(5'h00, 16'h0080, 1'b1);
        // a fault in the same cycle as a download start wins
        @(posedge clk);
        {download_start, compile_fault, compile_rule} <= {2'h3, 5'h01};
        @(posedge clk);
        {download_start, compile_fault} <= 2'h0;
        #1 chk(ccode, 32'h81);
        wr(OFS_CTRL, 32'h2, RESP_OKAY);
        rd(OFS_COMPILE, 32'h0, RESP_OKAY);
        wr(OFS_CTRL, 32'h1, RESP_OKAY);
        rd(OFS_CTRL, 32'h1, RESP_OKAY);
        wr(4'h2, 32'h0, RESP_DECERR);
        wr(OFS_CTRL, 32'h0, RESP_OKAY);
        rd(OFS_CTRL, 32'h0, RESP_OKAY);
        wr(OFS_ERROR, 32'hff, RESP_OKAY);
        rd(OFS_ERROR, 32'h1, RESP_OKAY);
        $display("compile codes done");
    endtask

    task wrap_up;
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence and watchdog
    initial begin
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        t_reset();
        t_wave();
        t_scan();
        t_exec();
        t_comp();
        wrap_up();
    end

    initial begin
        #100000;
        error_cnt++;
        wrap_up();
    end
endmodule
